// [bench/tb.sv]
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] CD = fcc_pkg::OFF_CLKDIV;
  localparam logic [11:0] PR = fcc_pkg::OFF_PROT;
  localparam logic [11:0] ST = fcc_pkg::OFF_STATUS;
  localparam logic [11:0] CM = fcc_pkg::OFF_CMD;
  localparam logic [11:0] AW = fcc_pkg::OFF_ARRWR;
  logic        mclk_i          = 1'b0;
  logic        rst_b_i         = 1'b0;
  logic        psel_i          = 1'b0;
  logic        penable_i       = 1'b0;
  logic        pwrite_i        = 1'b0;
  logic [11:0] paddr_i         = 12'h000;
  logic [31:0] pwdata_i        = 32'h0;
  logic [3:0]  pstrb_i         = 4'hf;
  logic        stop_mode_i     = 1'b0;
  logic        secure_i        = 1'b0;
  logic        nonsecure_src_i = 1'b0;
  logic        debug_mode_i    = 1'b0;
  logic        cell_erased_i   = 1'b1;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        op_busy_o;
  logic [7:0]  op_cmd_o;
  logic [15:0] op_addr_o;
  logic [15:0] op_data_o;
  logic [31:0] rdat;
  int          n_mismatch      = 0;
  int          tests_run       = 0;
  int          cyc             = 0;

  // Long op time so a second sequence can be buffered behind the first
  fcc_top #(.OP_LEN(20)) dut (.*, .pslverr_o());

  initial forever #10 mclk_i = ~mclk_i;

  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A hung handshake must still reach the verdict
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Idle cycle at the end keeps strobes from being re-raised at one edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel_i    <= 1'b1;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    rdat = prdata_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic st(input logic [31:0] m, e);
    apb(1'b0, ST, 32'h0);
    chk("status", rdat & m, e);
  endtask

  // three steps, no other write between
  task automatic seq(input logic [15:0] a, w, input logic [7:0] c);
    apb(1'b1, AW, {a, w});
    apb(1'b1, CM, {24'h0, c});
    apb(1'b1, ST, 32'h80);
  endtask

  task automatic clr();
    apb(1'b1, ST, 32'h30);
  endtask

  task automatic busy(input logic e);
    repeat (2) @(posedge mclk_i);
    #1;
    chk("op_busy", {31'h0, op_busy_o}, {31'h0, e});
    @(posedge mclk_i);
  endtask

  task automatic idle();
    while (op_busy_o !== 1'b0) @(posedge mclk_i);
    @(posedge mclk_i);
  endtask

  task automatic t_reset();
    st(32'hff, 32'hc0);
    apb(1'b0, PR, 32'h0);
    chk("protection", rdat, 32'hff);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", rdat, 32'h0);
    apb(1'b1, AW, 32'h02001234);
    st(32'hff, 32'hd0);
    apb(1'b1, ST, 32'h00);
    st(32'hff, 32'hd0);
    clr();
    st(32'hff, 32'hc0);
    apb(1'b1, CD, 32'h01);
    st(32'hff, 32'hc1);
  endtask

  // each word is programmed once, onto an erased cell
  task automatic t_prog();
    seq(16'h0246, 16'h1234, fcc_pkg::CMD_PROGRAM);
    busy(1'b1);
    chk("op_job", {op_cmd_o, op_addr_o[7:0], op_data_o}, 32'h20461234);
    st(32'hff, 32'h81);
    idle();
    st(32'hff, 32'hc1);
    seq(16'h0300, 16'h0001, fcc_pkg::CMD_PROGRAM);
    seq(16'h0302, 16'h0002, fcc_pkg::CMD_PROGRAM);
    while (op_addr_o !== 16'h0302) @(posedge mclk_i);
    st(32'hff, 32'h81);
    idle();
    st(32'hff, 32'hc1);
  endtask

  task automatic t_verify();
    seq(16'h5554, 16'haaaa, fcc_pkg::CMD_VERIFY);
    busy(1'b1);
    chk("op_cmd", {24'h0, op_cmd_o}, 32'h05);
    idle();
    st(32'hff, 32'hc5);
    cell_erased_i <= 1'b0;
    seq(16'h0000, 16'h0000, fcc_pkg::CMD_VERIFY);
    repeat (6) @(posedge mclk_i);
    busy(1'b0);
    st(32'hff, 32'hc1);
    cell_erased_i <= 1'b1;
  endtask

  task automatic t_prot();
    apb(1'b1, PR, 32'hfb);
    seq(16'h0100, 16'h0000, fcc_pkg::CMD_PROGRAM);
    busy(1'b0);
    st(32'h20, 32'h20);
    seq(16'h8000, 16'h0000, fcc_pkg::CMD_PROGRAM);
    busy(1'b0);
    clr();
    seq(16'h0100, 16'h0000, fcc_pkg::CMD_SECTOR);
    busy(1'b0);
    st(32'h20, 32'h20);
    clr();
    apb(1'b1, PR, 32'hdf);
    seq(16'h8000, 16'h0000, fcc_pkg::CMD_SECTOR);
    st(32'h20, 32'h20);
    clr();
    seq(16'h03fe, 16'hbeef, fcc_pkg::CMD_SECTOR);
    busy(1'b1);
    chk("op_cmd", {24'h0, op_cmd_o}, 32'h40);
    idle();
    apb(1'b1, PR, 32'h7f);
    seq(16'h0000, 16'h0000, fcc_pkg::CMD_MASS);
    busy(1'b0);
    st(32'hff, 32'he1);
    clr();
    apb(1'b1, PR, 32'hff);
    seq(16'h1110, 16'h2222, fcc_pkg::CMD_MASS);
    busy(1'b1);
    idle();
  endtask

  // Each pass breaks the three-step sequence in a different way: byte or misaligned word, bad command, wrong order, or zero buffer-flag write
  task automatic t_errs();
    for (int i = 0; i < 8; i++) begin
      if (i == 0)
        pstrb_i <= 4'h1;
      apb(1'b1, AW, (i == 1) ? 32'h02010000 : 32'h02000000);
      pstrb_i <= 4'hf;
      case (i)
        2: apb(1'b1, AW, 32'h02000000);
        3: apb(1'b1, PR, 32'hff);
        4: apb(1'b1, CM, 32'h06);
        default: apb(1'b1, CM, 32'h20);
      endcase
      case (i)
        5: apb(1'b1, PR, 32'hff);
        6: apb(1'b1, CM, 32'h20);
        7: apb(1'b1, ST, 32'h00);
        default: ;
      endcase
      apb(1'b1, ST, 32'h80);
      busy(1'b0);
      st(32'h10, 32'h10);
      clr();
    end
  endtask

  task automatic t_stop_sec();
    seq(16'h0400, 16'h0404, fcc_pkg::CMD_PROGRAM);
    busy(1'b1);
    stop_mode_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    busy(1'b0);
    stop_mode_i <= 1'b0;
    st(32'h10, 32'h10);
    clr();
    secure_i        <= 1'b1;
    nonsecure_src_i <= 1'b1;
    seq(16'h0500, 16'h0000, fcc_pkg::CMD_PROGRAM);
    busy(1'b0);
    st(32'h10, 32'h10);
    clr();
    nonsecure_src_i <= 1'b0;
    debug_mode_i    <= 1'b1;
    seq(16'h0000, 16'h0000, fcc_pkg::CMD_MASS);
    busy(1'b1);
    idle();
    st(32'hff, 32'hc1);
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    t_reset();
    t_prog();
    t_verify();
    t_prot();
    t_errs();
    t_stop_sec();
    tally_and_finish();
  end
endmodule

// [inc/fcc_pkg.sv]
// Package for the flash command controller: offsets, codes, carriers
package fcc_pkg;
  localparam logic [11:0] OFF_CLKDIV  = 12'h000;
  localparam logic [11:0] OFF_PROT    = 12'h004;
  localparam logic [11:0] OFF_STATUS  = 12'h008;
  localparam logic [11:0] OFF_CMD     = 12'h00c;
  localparam logic [11:0] OFF_CTRL    = 12'h010;
  localparam logic [11:0] OFF_ADDR    = 12'h014;
  localparam logic [11:0] OFF_DATA    = 12'h018;
  localparam logic [11:0] OFF_ARRWR   = 12'h01c;
  localparam logic [7:0] CMD_VERIFY   = 8'h05;
  localparam logic [7:0] CMD_PROGRAM  = 8'h20;
  localparam logic [7:0] CMD_SECTOR   = 8'h40;
  localparam logic [7:0] CMD_MASS     = 8'h41;
  localparam int ST_BUF_EMPTY = 7;
  localparam int ST_COMPLETE  = 6;
  localparam int ST_PROT_VIOL = 5;
  localparam int ST_ACC_ERR   = 4;
  localparam int ST_BLANK     = 2;
  localparam int ST_DIV_LOAD  = 0;
  localparam int PR_OPEN      = 7;
  localparam int PR_HIGH_DIS  = 5;
  localparam int PR_LOW_DIS   = 2;
  localparam int SECTOR_LSB   = 9;
  localparam logic [7:0] PROT_RESET   = 8'hff;
  localparam logic [7:0] CLKDIV_RESET = 8'h00;
  localparam int OP_CYCLES   = 16;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [15:0] data;
  } fcc_job_s;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_WORD = 4'b0010,
    SEQ_CMD  = 4'b0100,
    SEQ_LOCK = 4'b1000
  } fcc_seq_e;
endpackage

// [src/fcc_top.sv]
// Flash command controller with APB register slave
// Operation
// R1 - Code 05 checks array; blank flag if erased
// R2 - Verify stops at first unerased location
// R3 - Verify and mass erase ignore address, data
// R4 - Code 20 programs captured word at address
// R5 - Protected program target sets violation, no launch
// R6 - Code 40 erases sector; low nine bits ignored
// R7 - Protected sector sets violation, no launch
// R8 - Mass erase needs all protection disabled
// R9 - Complete flag only after buffered commands finish
// R10 - Software programs only erased words
// R11 - Array write before divider write: access error
// R12 - Byte or misaligned array write: access error
// R13 - Array write with buffer busy: access error
// R14 - Second word or other register: access error
// R15 - Bad or second command: access error
// R16 - After command only status write allowed
// R17 - Stop mode aborts operation, kills buffer
// R18 - Secure nonsecure or debug non-mass: error
// R19 - Writing zero to buffer flag aborts
// R20 - Reads never set access error
// R21 - Access error locks controller until cleared
// R22 - Violation locks controller until cleared
// R23 - Software issues word, command, launch
// R24 - Launch clears complete, refills buffer flag
// R25 - Divider write sets divider loaded flag
// R26 - Error flags clear by writing one
`timescale 1ns/1ps
module fcc_top #(
  parameter int OP_LEN = fcc_pkg::OP_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // System status
  input  wire logic        stop_mode_i,
  input  wire logic        secure_i,
  input  wire logic        nonsecure_src_i,
  input  wire logic        debug_mode_i,
  // Array engine view
  input  wire logic        cell_erased_i,
  output logic             op_busy_o,
  output logic [7:0]       op_cmd_o,
  output logic [15:0]      op_addr_o,
  output logic [15:0]      op_data_o
);
  logic             stop_q1, stop_q2;
  logic [7:0]       clkdiv, prot;
  logic             div_loaded;
  logic             buf_empty, complete, prot_viol, acc_err, blank;
  // Local names for the sequence states, so the case items stay short
  localparam fcc_pkg::fcc_seq_e SEQ_IDLE = fcc_pkg::SEQ_IDLE;
  localparam fcc_pkg::fcc_seq_e SEQ_WORD = fcc_pkg::SEQ_WORD;
  localparam fcc_pkg::fcc_seq_e SEQ_CMD  = fcc_pkg::SEQ_CMD;
  localparam fcc_pkg::fcc_seq_e SEQ_LOCK = fcc_pkg::SEQ_LOCK;
  fcc_pkg::fcc_seq_e seq;
  logic             buf_full;
  fcc_pkg::fcc_job_s pend, act;
  logic             active;
  logic [15:0]      cnt;
  logic             wr, rd;
  logic [11:0]      off;
  logic             arr_wr, arr_ok, cmd_wr, st_wr, oth_wr, launch, sabort;
  logic             locked, cmd_valid, cmd_prot, sec_bad, bad_arr;
  logic             word_prot, sec_prot, op_done, verify_fail;

  function automatic logic valid_cmd(input logic [7:0] c);
    return c == fcc_pkg::CMD_VERIFY || c == fcc_pkg::CMD_PROGRAM ||
           c == fcc_pkg::CMD_SECTOR || c == fcc_pkg::CMD_MASS;
  endfunction

  // Protected when region bit is low (disable clear); top half high region
  function automatic logic in_prot(input logic [15:0] a,
                                   input logic [7:0] p);
    return a[15] ? !p[fcc_pkg::PR_HIGH_DIS] : !p[fcc_pkg::PR_LOW_DIS];
  endfunction

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_q1 <= 1'b0;
      stop_q2 <= 1'b0;
    end else begin
      stop_q1 <= stop_mode_i;
      stop_q2 <= stop_q1;
    end
  end

  // Zero wait state slave; writes act in the access cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  assign wr  = psel_i && penable_i && pwrite_i;
  assign rd  = psel_i && penable_i && !pwrite_i;
  assign off = paddr_i;

  // Array write carries a 16-bit word in the low lanes, address in the high
  assign arr_wr = wr && off == fcc_pkg::OFF_ARRWR;
  assign arr_ok = pstrb_i[1:0] == 2'b11 && !pwdata_i[16];
  assign cmd_wr = wr && off == fcc_pkg::OFF_CMD;
  assign st_wr  = wr && off == fcc_pkg::OFF_STATUS;
  assign oth_wr = wr && !arr_wr && !cmd_wr && !st_wr;
  assign locked = acc_err || prot_viol;
  assign cmd_valid = valid_cmd(pwdata_i[7:0]);
  assign word_prot = in_prot(pend.addr, prot);
  assign sec_prot  = in_prot({pend.addr[15:fcc_pkg::SECTOR_LSB],
                              9'h000}, prot);
  // R8 mass erase needs every disable bit
  assign cmd_prot = (pwdata_i[7:0] == fcc_pkg::CMD_MASS) ?
    !(prot[fcc_pkg::PR_OPEN] && prot[fcc_pkg::PR_HIGH_DIS] &&
      prot[fcc_pkg::PR_LOW_DIS]) :
    (pwdata_i[7:0] == fcc_pkg::CMD_PROGRAM) ? word_prot :
    (pwdata_i[7:0] == fcc_pkg::CMD_SECTOR)  ? sec_prot : 1'b0;
  // R18 secured parts accept only mass erase from untrusted sources
  assign sec_bad = secure_i && (nonsecure_src_i || debug_mode_i) &&
                   pwdata_i[7:0] != fcc_pkg::CMD_MASS;
  // R11 R12 R13 R14 illegal array writes
  assign bad_arr = !div_loaded || !arr_ok || !buf_empty ||
                   seq != SEQ_IDLE;
  assign launch = st_wr && seq == SEQ_CMD &&
                  pwdata_i[fcc_pkg::ST_BUF_EMPTY] && !locked;
  // R19 zero to buffer flag mid-sequence aborts
  assign sabort = st_wr && seq != SEQ_IDLE &&
                  !pwdata_i[fcc_pkg::ST_BUF_EMPTY];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clkdiv     <= fcc_pkg::CLKDIV_RESET;
      div_loaded <= 1'b0;
      prot       <= fcc_pkg::PROT_RESET;
    end else begin
      // R25 divider write marks loaded
      if (wr && off == fcc_pkg::OFF_CLKDIV) begin
        clkdiv     <= pwdata_i[7:0];
        div_loaded <= 1'b1;
      end
      if (wr && off == fcc_pkg::OFF_PROT && seq == SEQ_IDLE)
        prot <= pwdata_i[7:0];
    end
  end

  // Sequence tracker; an illegal step drops the sequence and locks
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq <= SEQ_IDLE;
      pend <= '0;
    end else begin
      unique case (seq)
        SEQ_IDLE: begin
          if (arr_wr && !locked && !bad_arr) begin
            seq <= SEQ_WORD;
            pend.addr <= pwdata_i[31:16];
            pend.data <= pwdata_i[15:0];
          end
        end
        SEQ_WORD: begin
          // R15 R18 R5 R7 R8 command checked on write
          if (cmd_wr) begin
            if (!cmd_valid || sec_bad || cmd_prot)
              seq <= SEQ_IDLE;
            else begin
              seq <= SEQ_CMD;
              pend.cmd <= pwdata_i[7:0];
            end
          // R14 any other write aborts
          end else if (arr_wr || oth_wr || st_wr)
            seq <= SEQ_IDLE;
        end
        SEQ_CMD: begin
          // R16 only the status launch is allowed
          if (wr)
            seq <= SEQ_IDLE;
        end
        SEQ_LOCK: seq <= SEQ_IDLE;
        default: seq <= SEQ_IDLE;
      endcase
      if (stop_q2)
        seq <= SEQ_IDLE;
    end
  end

  // Two-stage pipe: pending job waits for the active one
  assign op_done = active && (cnt == 16'(OP_LEN - 1) || verify_fail);
  // R2 verify ends at first unerased cell
  assign verify_fail = active && act.cmd == fcc_pkg::CMD_VERIFY &&
                       !cell_erased_i;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active   <= 1'b0;
      buf_full <= 1'b0;
      act      <= '0;
      cnt      <= 16'h0000;
    end else begin
      if (launch)
        buf_full <= 1'b1;
      if (active)
        cnt <= cnt + 16'h0001;
      if (op_done)
        active <= 1'b0;
      // R3 R4 R6 captured job goes to engine
      if ((buf_full || launch) && (!active || op_done) && !launch) begin
        act      <= pend;
        active   <= 1'b1;
        buf_full <= 1'b0;
        cnt      <= 16'h0000;
      end
      // R17 stop aborts and kills buffered job
      if (stop_q2) begin
        active   <= 1'b0;
        buf_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_empty <= 1'b1;
      complete  <= 1'b1;
      blank     <= 1'b0;
    end else begin
      // R24 launch clears complete, buffer refills later
      if (launch) begin
        buf_empty <= 1'b0;
        complete  <= 1'b0;
        blank     <= 1'b0;
      end else if (!buf_full && !buf_empty)
        buf_empty <= 1'b1;
      // R1 blank flag when verify reaches end
      if (op_done && act.cmd == fcc_pkg::CMD_VERIFY && !verify_fail)
        blank <= 1'b1;
      // R9 complete only when nothing is buffered
      if (op_done && !buf_full && !launch)
        complete <= 1'b1;
      if (stop_q2) begin
        complete  <= 1'b1;
        buf_empty <= 1'b1;
      end
    end
  end

  // Error flags; set wins over a same-cycle clear
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_err   <= 1'b0;
      prot_viol <= 1'b0;
    end else begin
      // R26 write one clears
      if (st_wr && pwdata_i[fcc_pkg::ST_ACC_ERR])
        acc_err <= 1'b0;
      if (st_wr && pwdata_i[fcc_pkg::ST_PROT_VIOL])
        prot_viol <= 1'b0;
      // R11 R12 R13 R14 R15 R16 R17 R18 R19 R20 writes, or stop during an active operation
      if ((arr_wr && (bad_arr && !locked)) ||
          (seq == SEQ_WORD && (oth_wr || arr_wr || st_wr)) ||
          (seq == SEQ_WORD && cmd_wr && (!cmd_valid || sec_bad)) ||
          (seq == SEQ_IDLE && cmd_wr) ||
          (seq == SEQ_CMD && (oth_wr || arr_wr || cmd_wr)) ||
          sabort || (stop_q2 && active))
        acc_err <= 1'b1;
      // R22 R5 R7 violation on protected target
      if (seq == SEQ_WORD && cmd_wr && cmd_valid && !sec_bad && cmd_prot)
        prot_viol <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        fcc_pkg::OFF_CLKDIV: prdata_o <= {24'h000000, clkdiv};
        fcc_pkg::OFF_PROT:   prdata_o <= {24'h000000, prot};
        fcc_pkg::OFF_STATUS: prdata_o <= {24'h000000, buf_empty, complete,
                               prot_viol, acc_err, 1'b0, blank, 1'b0,
                               div_loaded};
        fcc_pkg::OFF_CMD:    prdata_o <= {24'h000000, pend.cmd};
        fcc_pkg::OFF_CTRL:   prdata_o <= {30'h0, buf_full, active};
        fcc_pkg::OFF_ADDR:   prdata_o <= {16'h0000, pend.addr};
        fcc_pkg::OFF_DATA:   prdata_o <= {16'h0000, pend.data};
        default:             prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  assign op_busy_o = active;
  assign op_cmd_o  = act.cmd;
  assign op_addr_o = act.addr;
  assign op_data_o = act.data;

  // R21 no launch while access error stands
  a_lock_acc: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    acc_err |-> !launch) else $error("launch while access error"); // R21
  a_lock_pv: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    prot_viol |-> !launch) else $error("launch while violation"); // R22
  a_div_load: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr && off == fcc_pkg::OFF_CLKDIV) |=> div_loaded)
    else $error("divider flag not set"); // R25
  a_early_arr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (arr_wr && !div_loaded && !locked) |=> acc_err && seq == SEQ_IDLE)
    else $error("early array write accepted"); // R11
  a_bad_cmd: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (seq == SEQ_WORD && cmd_wr && !cmd_valid) |=> acc_err)
    else $error("bad command accepted"); // R15
  a_launch_cc: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    launch |=> !complete && !buf_empty)
    else $error("launch flags wrong"); // R24
  a_stop_kill: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (stop_q2 && active) |=> !active && !buf_full && acc_err)
    else $error("stop did not abort"); // R17
  a_zero_abort: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    sabort |=> acc_err && seq == SEQ_IDLE)
    else $error("zero write did not abort"); // R19
  a_read_clean: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!wr && !stop_q2 && !acc_err) |=> !acc_err)
    else $error("error without write"); // R20
  a_pend_cc: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (op_done && buf_full && !stop_q2) |=> !complete)
    else $error("complete with buffered job"); // R9

  // Protection checks act on the command write itself
  a_prog_prot: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (seq == SEQ_WORD && cmd_wr && cmd_valid && !sec_bad && cmd_prot)
    |=> prot_viol && seq == SEQ_IDLE) else $error("no violation"); // R5
  a_sect_prot: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (seq == SEQ_WORD && cmd_wr && !sec_bad && sec_prot &&
     pwdata_i[7:0] == fcc_pkg::CMD_SECTOR) |=> prot_viol)
    else $error("protected sector accepted"); // R7
  a_mass_prot: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (seq == SEQ_WORD && cmd_wr && !sec_bad && !prot[fcc_pkg::PR_OPEN] &&
     pwdata_i[7:0] == fcc_pkg::CMD_MASS) |=> prot_viol && seq != SEQ_CMD)
    else $error("mass erase while protected"); // R8

  // Result flag and job hand-over
  a_blank_set: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (op_done && act.cmd == fcc_pkg::CMD_VERIFY && !verify_fail && !launch)
    |=> blank) else $error("blank flag not set"); // R1
  a_verify_stop: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    verify_fail |=> !blank)
    else $error("blank after unerased cell"); // R2
  a_job_move: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!active && buf_full && !launch && !stop_q2)
    |=> active && op_addr_o == $past(pend.addr))
    else $error("job address lost"); // R4
  a_buf_refill: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!launch && !buf_full && !buf_empty) |=> buf_empty)
    else $error("buffer flag not refilled"); // R24

  // Access error set, hold and clear
  a_busy_arr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (arr_wr && !buf_empty && !locked) |=> acc_err)
    else $error("array write while buffer full"); // R13
  a_after_cmd: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (seq == SEQ_CMD && wr && !st_wr) |=> acc_err)
    else $error("write after command accepted"); // R16
  a_acc_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (st_wr && pwdata_i[fcc_pkg::ST_ACC_ERR] && seq == SEQ_IDLE &&
     !(stop_q2 && active)) |=> !acc_err)
    else $error("access error not cleared"); // R26
  a_acc_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (acc_err && !(st_wr && pwdata_i[fcc_pkg::ST_ACC_ERR])) |=> acc_err)
    else $error("access error lost"); // R26
  c_launch: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    launch);
  c_pipe: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    active && buf_full);
  c_viol: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(prot_viol));
  c_blank: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(blank));
  c_stop: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    stop_q2 && active);
endmodule
